/* File: src/standby_conversion_control.sv */
// Standby, halt and one-shot control of the two-channel converter
`timescale 1ns/10ps
`default_nettype none

module standby_conversion_control #(
  parameter int unsigned CONV_CYCLES = standby_pin_n_pkg::CONV_CYCLES
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic standby_pin_n_in,
  input wire logic halt_bit_in,
  input wire logic one_shot_in,
  input wire logic [standby_pin_n_pkg::RATE_W-1:0] rate_sel_in,
  input wire logic [standby_pin_n_pkg::TEMP_W-1:0] remote_sample_in,
  input wire logic [standby_pin_n_pkg::TEMP_W-1:0] local_sample_in,
  output logic adc_enable_out,
  output logic channel_remote_out,
  output logic busy_out,
  output logic standby_out,
  output logic conv_done_out,
  output logic [standby_pin_n_pkg::TEMP_W-1:0] remote_temp_out,
  output logic [standby_pin_n_pkg::TEMP_W-1:0] local_temp_out
);
  import standby_pin_n_pkg::*;

  // ==========================================================
  // Elaboration check
  localparam int unsigned PHASE_CYCLES = CONV_CYCLES / 2;
  localparam logic [TIMER_W-1:0] PHASE_W = TIMER_W'(PHASE_CYCLES);
  localparam logic [TIMER_W-1:0] CONV_W = TIMER_W'(CONV_CYCLES);

  initial begin
    if (CONV_CYCLES < 4 || CONV_CYCLES > 32'h01000000 ||
        (CONV_CYCLES % 2) != 0) begin
      $error("CONV_CYCLES must be even and between 4 and 2^24");
    end
  end

  // ==========================================================
  // Standby decode
  logic hw_standby_pin_n;
  logic sw_standby_pin_n;
  logic standby_pin_n;
  logic os_start;
  logic oneshot_q;
  logic abort;

  assign hw_standby_pin_n = !standby_pin_n_in;
  assign sw_standby_pin_n = halt_bit_in;
  assign standby_pin_n = hw_standby_pin_n || sw_standby_pin_n;
  assign os_start = one_shot_in && !hw_standby_pin_n;
  assign abort = hw_standby_pin_n || (sw_standby_pin_n && !oneshot_q);

  // ==========================================================
  // Rate interval
  logic [TIMER_W-1:0] periods;
  logic [TIMER_W-1:0] idle_cycles;

  always_comb begin
    periods = (32'h1 << (RATE_SEL_MAX - rate_sel_in)) - 32'h1;
    idle_cycles = periods * CONV_W;
  end

  // ==========================================================
  // Sequencer
  conv_state_t state_q;
  conv_state_t state_d;
  logic tmr_done;
  logic tmr_load;
  logic tmr_clear;
  logic [TIMER_W-1:0] tmr_val;
  logic commit;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (os_start || !standby_pin_n) begin
          state_d = ST_REMOTE;
        end
      end
      ST_REMOTE: begin
        if (abort) begin
          state_d = ST_IDLE;
        end else if (tmr_done) begin
          state_d = ST_LOCAL;
        end
      end
      ST_LOCAL: begin
        if (abort) begin
          state_d = ST_IDLE;
        end else if (tmr_done) begin
          if (standby_pin_n) begin
            state_d = ST_IDLE;
          end else if (idle_cycles == '0) begin
            state_d = ST_REMOTE;
          end else begin
            state_d = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (standby_pin_n) begin
          state_d = ST_IDLE;
        end else if (os_start || tmr_done) begin
          state_d = ST_REMOTE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // One-shot run flag, set only for a conversion started in software standby, cleared when it ends
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      oneshot_q <= 1'b0;
    end else if (state_q != ST_REMOTE && state_d == ST_REMOTE) begin
      oneshot_q <= standby_pin_n;
    end else if (state_d == ST_IDLE || state_d == ST_WAIT) begin
      oneshot_q <= 1'b0;
    end
  end

  // ==========================================================
  // Phase timer
  assign tmr_load = (state_d != state_q) && (state_d != ST_IDLE);
  assign tmr_clear = (state_d == ST_IDLE);
  assign tmr_val = (state_d == ST_WAIT) ? idle_cycles : PHASE_W;

  phase_timer #(
    .WIDTH(TIMER_W)
  ) u_timer (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .load_in(tmr_load),
    .clear_in(tmr_clear),
    .load_val_in(tmr_val),
    .done_out(tmr_done)
  );

  // ==========================================================
  // Results
  logic [TEMP_W-1:0] remote_pend_q;
  logic [TEMP_W-1:0] remote_temp_q;
  logic [TEMP_W-1:0] local_temp_q;

  assign commit = (state_q == ST_LOCAL) && tmr_done && !abort;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      remote_pend_q <= RESULT_RESET;
    end else if (state_q == ST_REMOTE && tmr_done && !abort) begin
      remote_pend_q <= remote_sample_in;
    end
  end

  // Written only on a completed cycle; held in hardware standby, and in software standby except by a one-shot conversion
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      remote_temp_q <= RESULT_RESET;
      local_temp_q <= RESULT_RESET;
    end else if (commit) begin
      remote_temp_q <= remote_pend_q;
      local_temp_q <= local_sample_in;
    end
  end

  // Results are never gated, so host reads see them at all times
  assign remote_temp_out = remote_temp_q;
  assign local_temp_out = local_temp_q;

  // ==========================================================
  // Status outputs
  assign adc_enable_out = (state_q == ST_REMOTE) || (state_q == ST_LOCAL);
  assign busy_out = adc_enable_out;
  assign channel_remote_out = (state_q == ST_REMOTE);
  assign standby_out = standby_pin_n;
  assign conv_done_out = commit;

  // ==========================================================
  // Checks
  logic [TIMER_W-1:0] busy_cnt_q;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_cnt_q <= '0;
    end else if (!busy_out || commit) begin
      busy_cnt_q <= '0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 32'h1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_oneshot_in_sw;
    state_q == ST_IDLE && sw_standby_pin_n && !hw_standby_pin_n && one_shot_in;
  endsequence

  sequence s_remote_start;
    busy_out && channel_remote_out;
  endsequence

  chk_hw_idle: assert property (
    hw_standby_pin_n |=> !adc_enable_out
  ) else $error("converter ran in hardware standby");

  chk_hw_oneshot: assert property (
    hw_standby_pin_n && one_shot_in && !busy_out |=> !busy_out
  ) else $error("one-shot started in hardware standby");

  chk_sw_oneshot: assert property (
    s_oneshot_in_sw |=> s_remote_start
  ) else $error("one-shot ignored in software standby");

  chk_abort_now: assert property (
    busy_out && (hw_standby_pin_n || (sw_standby_pin_n && !oneshot_q)) |=> !busy_out
  ) else $error("conversion not aborted at once");

  chk_hold_results: assert property (
    !commit |=> $stable(remote_temp_out) && $stable(local_temp_out)
  ) else $error("result changed without a completed cycle");

  chk_conv_length: assert property (
    commit |-> busy_cnt_q == CONV_W - 32'h1
  ) else $error("conversion length wrong");

  chk_two_phase: assert property (
    busy_out && $fell(channel_remote_out) |-> busy_cnt_q == PHASE_W
  ) else $error("remote phase length wrong");

  chk_fast_rate: assert property (
    commit && !standby_pin_n && rate_sel_in == RATE_SEL_MAX |=> s_remote_start
  ) else $error("fastest rate left a gap");

  chk_busy_flag: assert property (
    busy_out |-> busy_cnt_q < CONV_W
  ) else $error("busy held beyond one conversion");

  chk_oneshot_end: assert property (
    commit && sw_standby_pin_n && !one_shot_in |=> !busy_out [*4]
  ) else $error("conversion continued after one-shot");

endmodule
`default_nettype wire

/* File: common/standby_pin_n_pkg.sv */
// Shared constants and state encoding for standby and conversion control
package standby_pin_n_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_KHZ = 25000;
  localparam int unsigned CONV_TIME_MS = 125;
  localparam int unsigned CONV_CYCLES = CONV_TIME_MS * CLK_KHZ;
  localparam int unsigned FASTEST_RATE_HZ = 8;
  localparam int unsigned TIMER_W = 32;

  // ==========================================================
  // Rate select and data
  localparam int unsigned RATE_W = 3;
  localparam logic [RATE_W-1:0] RATE_SEL_MAX = 3'h7;
  localparam int unsigned TEMP_W = 8;
  localparam logic [TEMP_W-1:0] RESULT_RESET = 8'h00;

  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_REMOTE = 4'h2,
    ST_LOCAL = 4'h4,
    ST_WAIT = 4'h8
  } conv_state_t;

endpackage

/* File: src/phase_timer.sv */
// Down-counting phase timer with load, clear and done pulse
`timescale 1ns/10ps
`default_nettype none

module phase_timer #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic load_in,
  input wire logic clear_in,
  input wire logic [WIDTH-1:0] load_val_in,
  output logic done_out
);

  // ==========================================================
  // Elaboration check
  initial begin
    if (WIDTH < 2) begin
      $error("phase_timer width too small");
    end
  end

  // ==========================================================
  // Counter
  logic [WIDTH-1:0] cnt_q;
  logic run_q;

  assign done_out = run_q && (cnt_q == '0);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (load_in) begin
      cnt_q <= load_val_in - {{(WIDTH-1){1'b0}}, 1'b1};
      run_q <= 1'b1;
    end else if (clear_in || done_out) begin
      run_q <= 1'b0;
    end else if (run_q) begin
      cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

/* File: bench/host_model.sv */
// Host model driving the halt bit and one-shot command
`timescale 1ns/10ps
`default_nettype none

module host_model (
  input wire logic clk_in,
  output logic halt_bit_out,
  output logic one_shot_out
);
  initial begin
    halt_bit_out = 1'b0;
    one_shot_out = 1'b0;
  end

  // =========================================
  // Command tasks
  task automatic set_halt(input logic v);
    @(posedge clk_in);
    halt_bit_out <= v;
  endtask

  // One-cycle one-shot command
  task automatic one_shot();
    @(posedge clk_in);
    one_shot_out <= 1'b1;
    @(posedge clk_in);
    one_shot_out <= 1'b0;
  endtask
endmodule

`default_nettype wire

/* File: bench/test_standby_conversion_control.sv */
// Testbench for standby and conversion control
`timescale 1ns/10ps
`default_nettype none

module test_standby_conversion_control;
  import standby_pin_n_pkg::*;
  localparam int unsigned CC = 8;
  logic clk_in, arst_n_in, pin_n, halt, shot, busy, done, adc, chr, standby_pin_n;
  logic [RATE_W-1:0] rate;
  logic [TEMP_W-1:0] rs, ls, rt, lt;
  int bad_count, check_count, n;

  standby_conversion_control #(.CONV_CYCLES(CC)) i_dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .standby_pin_n_in(pin_n),
    .halt_bit_in(halt), .one_shot_in(shot), .rate_sel_in(rate),
    .remote_sample_in(rs), .local_sample_in(ls), .adc_enable_out(adc),
    .channel_remote_out(chr), .busy_out(busy), .standby_out(standby_pin_n),
    .conv_done_out(done), .remote_temp_out(rt), .local_temp_out(lt));

  host_model i_host (.clk_in(clk_in), .halt_bit_out(halt),
    .one_shot_out(shot));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // =========================================
  // Helpers
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done();
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wait_done();
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 60) begin
      bad_count++;
      $display("[ERR] conv_done expected 1 seen timeout");
      test_done();
    end
  endtask

  // Nothing runs, results held
  task automatic quiet(input int c, input logic [7:0] r, input logic [7:0] l);
    repeat (c) begin
      @(negedge clk_in);
      chk("busy", 8'h00, {7'h0, busy});
      chk("adc", 8'h00, {7'h0, adc});
      chk("remote", r, rt);
      chk("local", l, lt);
    end
  endtask

  // =========================================
  // Scenarios
  task automatic t_free_run();
    @(negedge clk_in);
    wait_done();
    chk("remote_ch", 8'h00, {7'h0, chr});
    @(posedge clk_in);
    rs <= 8'h11;
    ls <= 8'h22;
    @(negedge clk_in);
    chk("remote", 8'h5a, rt);
    chk("local", 8'h3c, lt);
    chk("busy", 8'h01, {7'h0, busy});
    wait_done();
    chk("period", CC[7:0], 8'(n + 1));
  endtask

  task automatic t_hw_abort();
    @(posedge clk_in);
    rs <= 8'hee;
    ls <= 8'hee;
    repeat (3) @(posedge clk_in);
    pin_n <= 1'b0;
    @(negedge clk_in);
    chk("standby", 8'h01, {7'h0, standby_pin_n});
    @(negedge clk_in);
    chk("busy", 8'h00, {7'h0, busy});
    quiet(12, 8'h11, 8'h22);
    i_host.one_shot();
    quiet(12, 8'h11, 8'h22);
  endtask

  task automatic t_sw_one_shot();
    i_host.set_halt(1'b1);
    pin_n <= 1'b1;
    rs <= 8'h77;
    ls <= 8'h88;
    @(negedge clk_in);
    chk("standby", 8'h01, {7'h0, standby_pin_n});
    quiet(10, 8'h11, 8'h22);
    i_host.one_shot();
    @(negedge clk_in);
    chk("busy", 8'h01, {7'h0, busy});
    chk("remote", 8'h11, rt);
    wait_done();
    @(negedge clk_in);
    chk("remote", 8'h77, rt);
    chk("local", 8'h88, lt);
    quiet(20, 8'h77, 8'h88);
  endtask

  // Slower rate gap, one-shot in gap, halt aborts free run
  task automatic t_gap_halt();
    i_host.set_halt(1'b0);
    rate <= 3'h6;
    rs <= 8'h33;
    ls <= 8'h44;
    wait_done();
    quiet(8, 8'h33, 8'h44);
    wait_done();
    chk("gap_conv", CC[7:0], 8'(n));
    @(posedge clk_in);
    rs <= 8'h55;
    ls <= 8'h66;
    i_host.one_shot();
    @(negedge clk_in);
    chk("busy", 8'h01, {7'h0, busy});
    i_host.set_halt(1'b1);
    @(negedge clk_in);
    chk("standby", 8'h01, {7'h0, standby_pin_n});
    @(negedge clk_in);
    chk("busy", 8'h00, {7'h0, busy});
    quiet(12, 8'h33, 8'h44);
  endtask

  initial begin
    bad_count = 0;
    check_count = 0;
    arst_n_in = 1'b0;
    pin_n = 1'b1;
    rate = RATE_SEL_MAX;
    rs = 8'h5a;
    ls = 8'h3c;
    repeat (8) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_free_run();
    t_hw_abort();
    t_sw_one_shot();
    t_gap_halt();
    test_done();
  end
endmodule

`default_nettype wire
